/* core/sensor_output_defines.svh */
`ifndef SENSOR_OUTPUT_DEFINES_SVH
`define SENSOR_OUTPUT_DEFINES_SVH
// register indices on the serial control bus
`define PIN_OVERRIDE_ADDR 8'h15
`define READOUT_ORDER_ADDR 8'h16
`define OUTPUT_FORMAT_ADDR 8'h17
// reset values
`define PIN_OVERRIDE_RST 8'h00
`define READOUT_ORDER_RST 8'h03
`define OUTPUT_FORMAT_RST 8'h18
// pin override register fields
`define PO_ENABLE 0
`define PO_QUAL_BIT 1
`define PO_FRAME_BIT 2
`define PO_DRIVE_LO 3
`define PO_DRIVE_HI 4
// read-out order register fields
`define RO_VSHUFFLE 2
`define RO_HMIRROR 3
`define RO_VFLIP 4
`define RO_STROBE_TS 5
`define RO_QUAL_TS 6
`define RO_PREDIV 7
// output format register fields
`define OF_WIDTH_LO 0
`define OF_WIDTH_HI 1
`define OF_PASS 2
`define OF_DATA_TS 5
`define OF_RETIME 6
// drive strength codes
`define DRIVE_2MA 2'b00
`define DRIVE_4MA 2'b01
`define DRIVE_6MA 2'b10
// embedded code bytes
`define CODE_PREAMBLE 8'hff
`define CODE_ZERO 8'h00
`define CODE_SAV 8'h80
`define CODE_EAV 8'h90
`define CODE_LEN 3'd4
// pre-divider: 2 ticks in every 3 clocks
`define PREDIV_LAST 2'd2
// array address width
`define ADDR_W 9
`endif

/* core/sensor_output_pin_control.sv */
// Purpose: output pin control, read-out ordering, bus width and
//   embedded code insertion for the sensor video port.
// Assumes: register writes arrive already decoded from the serial
//   control bus; all inputs synchronous to clk_i.
// Notes: pin enables are active low; the pad ring resolves the wires;
//   reads return the stored register, never the deferred pin state;
//   row and column counts are parameters, address width is fixed.
//
// How it works
// - override maps register bits onto frame strobe and qualifier clock pins
// - drive field selects 2, 4, 6 mA
// - disabled outputs ignore drive strength
// - shuffle reads even rows then odd
// - mirror reverses column order per row
// - flip reverses row order
// - bit five tri-states frame/line strobes
// - reads return written bits immediately
// - bit six tri-states qualifier clock
// - bit seven divides input clock by 1.5
// - strobe disable is pin OR bit
// - qualifier disable is pin OR bit
// - format field picks 5, 4, 8 wires
// - eight-wire puts data bits on strobes
// - insert SAV/EAV unless pass-through set
// - data bus tri-state by bit or pin
// - retime bit defers tri-state to field
// - override enable bit defaults off
// - no codes disables frame strobe, qualifier conditional
`timescale 1ns/1ps
module sensor_output_pin_control
  import sensor_output_pkg::*;
#(
  parameter int ROWS = 292,
  parameter int COLS = 356
)(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic out_disable_pin_i,
  input wire logic field_start_i,
  input wire logic pix_adv_i,
  input wire logic sav_i,
  input wire logic eav_i,
  input wire logic [7:0] adc_data_i,
  input wire logic frame_strobe_i,
  input wire logic line_strobe_i,
  input wire logic qual_clk_i,
  input wire logic qual_clk_free_i,
  output logic [7:0] reg_rdata_o,
  output logic [7:0] data_o,
  output logic data_oe_b_o,
  output logic frame_strobe_pin_o,
  output logic frame_strobe_oe_b_o,
  output logic line_strobe_pin_o,
  output logic line_strobe_oe_b_o,
  output logic qualifier_clock_pin_o,
  output logic qualifier_clock_oe_b_o,
  output logic [1:0] drive_strength_o,
  output logic div_tick_o,
  output logic [`ADDR_W-1:0] row_addr_o,
  output logic [`ADDR_W-1:0] col_addr_o
);

  localparam logic [`ADDR_W-1:0] ROW_LAST = `ADDR_W'(ROWS - 1);
  localparam logic [`ADDR_W-1:0] COL_LAST = `ADDR_W'(COLS - 1);
  localparam logic [`ADDR_W-1:0] ROW_HALF = `ADDR_W'((ROWS + 1) / 2);

  // whole block state: one copy is built, one is registered
  state_t cur_ff;
  state_t nxt_ff;

  // =========================================================
  // address mapping
  // reverse an index when asked; shared by row and column paths
  // no underflow: a counter never passes its last index
  function automatic logic [`ADDR_W-1:0] rev_index(
    input logic [`ADDR_W-1:0] idx,
    input logic [`ADDR_W-1:0] last,
    input logic rev
  );
    rev_index = rev ? (last - idx) : idx;
  endfunction

  // shuffled row: first half even rows, second half odd rows
  // odd row counts round the half up, so the even half is the
  // longer of the two
  function automatic logic [`ADDR_W-1:0] shuffle_row(
    input logic [`ADDR_W-1:0] r,
    input logic on
  );
    logic [`ADDR_W-1:0] off;
    off = r - ROW_HALF;
    if (!on)
      shuffle_row = r;
    else if (r < ROW_HALF)
      shuffle_row = {r[`ADDR_W-2:0], 1'b0};
    else
      shuffle_row = {off[`ADDR_W-2:0], 1'b1};
  endfunction

  // =========================================================
  // next state
  always_comb
  begin
    logic oeb_strobe;
    logic oeb_qual;
    logic oeb_data;
    logic load_shadow;
    logic [7:0] out_byte;
    logic codes_on;
    logic wide;
    oeb_strobe = 1'b0;
    oeb_qual = 1'b0;
    oeb_data = 1'b0;
    load_shadow = 1'b0;
    out_byte = 8'h00;
    codes_on = 1'b0;
    wide = 1'b0;
    nxt_ff = cur_ff;

    // register writes; reads see the stored value at once
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `PIN_OVERRIDE_ADDR: nxt_ff.pin_ovr = reg_wdata_i;
        `READOUT_ORDER_ADDR: nxt_ff.rdo = reg_wdata_i;
        `OUTPUT_FORMAT_ADDR: nxt_ff.opf = reg_wdata_i;
        default: ;
      endcase
    end

    // read data stands until the next read, so a slow master
    // may fetch it late
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `PIN_OVERRIDE_ADDR: nxt_ff.rdata = cur_ff.pin_ovr;
        `READOUT_ORDER_ADDR: nxt_ff.rdata = cur_ff.rdo;
        `OUTPUT_FORMAT_ADDR: nxt_ff.rdata = cur_ff.opf;
        default: nxt_ff.rdata = 8'h00;
      endcase
    end

    // tri-state copies: immediate, or held until the field starts
    load_shadow = !cur_ff.opf[`OF_RETIME] || field_start_i;
    // the shadow copies feed the pin enables, so a write made while
    // retiming is on cannot glitch a pin in mid-field
    if (load_shadow)
    begin
      nxt_ff.eff_data_ts = cur_ff.opf[`OF_DATA_TS];
      nxt_ff.eff_strobe_ts = cur_ff.rdo[`RO_STROBE_TS];
      nxt_ff.eff_qual_ts = cur_ff.rdo[`RO_QUAL_TS];
    end

    // combined enables: either source disables a group
    oeb_strobe = out_disable_pin_i | cur_ff.eff_strobe_ts;
    oeb_qual = out_disable_pin_i | cur_ff.eff_qual_ts;
    oeb_data = out_disable_pin_i | cur_ff.eff_data_ts;
    nxt_ff.data_oe_b = oeb_data;
    nxt_ff.frame_oe_b = oeb_strobe;
    nxt_ff.line_oe_b = oeb_strobe;
    nxt_ff.qual_oe_b = oeb_qual;

    // drive field only matters while something is driven;
    // a code of 11 is passed on as written, software must avoid it
    if (oeb_strobe && oeb_qual && oeb_data)
      nxt_ff.drive = `DRIVE_2MA;
    else
      nxt_ff.drive = cur_ff.pin_ovr[`PO_DRIVE_HI:`PO_DRIVE_LO];

    // pre-divider: drop one tick in three, giving 2/3 the rate
    // counter is held at zero while off, so the first tick after
    // enabling comes from a known phase
    if (cur_ff.rdo[`RO_PREDIV])
    begin
      nxt_ff.div_cnt = (cur_ff.div_cnt == `PREDIV_LAST) ?
                       2'd0 : cur_ff.div_cnt + 2'd1;
      nxt_ff.div_tick = (nxt_ff.div_cnt != `PREDIV_LAST);
    end
    else
    begin
      nxt_ff.div_cnt = 2'd0;
      nxt_ff.div_tick = 1'b1;
    end

    // read-out sequencer, restarted by each field
    // wraps silently at the last row; a field start beats an advance
    if (field_start_i)
    begin
      nxt_ff.row = '0;
      nxt_ff.col = '0;
    end
    else if (pix_adv_i)
    begin
      if (cur_ff.col == COL_LAST)
      begin
        nxt_ff.col = '0;
        nxt_ff.row = (cur_ff.row == ROW_LAST) ? '0 : cur_ff.row + 1'b1;
      end
      else
        nxt_ff.col = cur_ff.col + 1'b1;
    end

    // physical address: shuffle, then flip; column mirror on its own
    nxt_ff.row_addr = rev_index(
      shuffle_row(cur_ff.row, cur_ff.rdo[`RO_VSHUFFLE]),
      ROW_LAST, cur_ff.rdo[`RO_VFLIP]);
    nxt_ff.col_addr = rev_index(cur_ff.col, COL_LAST,
                                cur_ff.rdo[`RO_HMIRROR]);

    // embedded code sequence: ff 00 00 xy, then video resumes
    codes_on = !cur_ff.opf[`OF_PASS];
    if (cur_ff.code_cnt != 3'd0)
      nxt_ff.code_cnt = cur_ff.code_cnt - 3'd1;
    // requests while a sequence runs are dropped, not queued
    if (codes_on && (sav_i || eav_i) && cur_ff.code_cnt == 3'd0)
    begin
      nxt_ff.code_cnt = `CODE_LEN;
      nxt_ff.code_eav = eav_i;
    end

    // byte chosen by the count: preamble first, status word last
    case (cur_ff.code_cnt)
      3'd4: out_byte = `CODE_PREAMBLE;
      3'd3: out_byte = `CODE_ZERO;
      3'd2: out_byte = `CODE_ZERO;
      3'd1: out_byte = cur_ff.code_eav ? `CODE_EAV : `CODE_SAV;
      default: out_byte = adc_data_i;
    endcase
    if (!codes_on)
      out_byte = adc_data_i;

    // bus width: narrow modes send high nibble then low nibble
    // the low nibble is latched with the high one, so a byte
    // change in mid-pair cannot tear a pixel
    wide = cur_ff.opf[`OF_WIDTH_HI];
    if (wide)
    begin
      nxt_ff.nib_phase = 1'b0;
      nxt_ff.data = out_byte;
    end
    else
    begin
      nxt_ff.nib_phase = !cur_ff.nib_phase;
      if (!cur_ff.nib_phase)
        nxt_ff.byte_hold = out_byte;
      nxt_ff.data = 8'h00;
      nxt_ff.data[3:0] = cur_ff.nib_phase ? cur_ff.byte_hold[3:0] :
                         out_byte[7:4];
      // fifth wire marks the high nibble
      if (bus_width_t'(cur_ff.opf[1:0]) == BUS_5WIRE)
        nxt_ff.data[4] = !cur_ff.nib_phase;
    end

    // strobe pins: normal, overridden, or carrying data bits
    // later assignments win: data bits beat override beats normal
    nxt_ff.line = line_strobe_i;
    nxt_ff.frame = codes_on ? frame_strobe_i : 1'b0;
    nxt_ff.qual = (codes_on || qual_clk_free_i) ? qual_clk_i : 1'b0;
    if (cur_ff.pin_ovr[`PO_ENABLE])
    begin
      nxt_ff.frame = cur_ff.pin_ovr[`PO_FRAME_BIT];
      nxt_ff.qual = cur_ff.pin_ovr[`PO_QUAL_BIT];
    end
    if (wide)
    begin
      nxt_ff.frame = out_byte[5];
      nxt_ff.line = out_byte[6];
    end
  end

  // =========================================================
  // state register
  // reset loads the register defaults and sets div_tick, all else starts at zero
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cur_ff <= '0;
      cur_ff.pin_ovr <= `PIN_OVERRIDE_RST;
      cur_ff.rdo <= `READOUT_ORDER_RST;
      cur_ff.opf <= `OUTPUT_FORMAT_RST;
      cur_ff.div_tick <= 1'b1;
    end
    else
      cur_ff <= nxt_ff;
  end

  // outputs straight from the state register
  assign reg_rdata_o = cur_ff.rdata;
  assign data_o = cur_ff.data;
  assign data_oe_b_o = cur_ff.data_oe_b;
  assign frame_strobe_pin_o = cur_ff.frame;
  assign frame_strobe_oe_b_o = cur_ff.frame_oe_b;
  assign line_strobe_pin_o = cur_ff.line;
  assign line_strobe_oe_b_o = cur_ff.line_oe_b;
  assign qualifier_clock_pin_o = cur_ff.qual;
  assign qualifier_clock_oe_b_o = cur_ff.qual_oe_b;
  assign drive_strength_o = cur_ff.drive;
  assign div_tick_o = cur_ff.div_tick;
  assign row_addr_o = cur_ff.row_addr;
  assign col_addr_o = cur_ff.col_addr;

endmodule

/* core/sensor_output_pkg.sv */
`include "sensor_output_defines.svh"
package sensor_output_pkg;
  typedef enum logic [1:0] {
    BUS_5WIRE = 2'b00,
    BUS_4WIRE = 2'b01,
    BUS_8WIRE = 2'b10
  } bus_width_t;

  typedef struct packed {
    logic [7:0] pin_ovr;
    logic [7:0] rdo;
    logic [7:0] opf;
    logic eff_data_ts;
    logic eff_strobe_ts;
    logic eff_qual_ts;
    logic [`ADDR_W-1:0] row;
    logic [`ADDR_W-1:0] col;
    logic [1:0] div_cnt;
    logic nib_phase;
    logic [7:0] byte_hold;
    logic [2:0] code_cnt;
    logic code_eav;
    logic [7:0] rdata;
    logic [7:0] data;
    logic data_oe_b;
    logic frame;
    logic frame_oe_b;
    logic line;
    logic line_oe_b;
    logic qual;
    logic qual_oe_b;
    logic [1:0] drive;
    logic div_tick;
    logic [`ADDR_W-1:0] row_addr;
    logic [`ADDR_W-1:0] col_addr;
  } state_t;
endpackage

/* sim/pin_ctrl_sva.sv */
// Purpose: port checks for the pin control block
// Assumes: one clock, async low reset
// Notes: bound onto the design top
`timescale 1ns/1ps
`include "sensor_output_defines.svh"
module pin_ctrl_sva(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic out_disable_pin_i,
  input wire logic field_start_i,
  input wire logic pix_adv_i,
  input wire logic sav_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic data_oe_b_o,
  input wire logic frame_strobe_oe_b_o,
  input wire logic line_strobe_oe_b_o,
  input wire logic qualifier_clock_oe_b_o,
  input wire logic [1:0] drive_strength_o,
  input wire logic div_tick_o,
  input wire logic [`ADDR_W-1:0] col_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic all_off;
  // =====================
  // enables
  assign all_off = data_oe_b_o && frame_strobe_oe_b_o
    && line_strobe_oe_b_o && qualifier_clock_oe_b_o;
  data_off_a: assert property (out_disable_pin_i |=> data_oe_b_o)
    else $error("data bus driven while disabled");
  strobe_off_a: assert property (out_disable_pin_i |=>
    frame_strobe_oe_b_o && line_strobe_oe_b_o)
    else $error("strobes driven while disabled");
  qual_off_a: assert property (out_disable_pin_i |=>
    qualifier_clock_oe_b_o)
    else $error("qualifier clock driven while disabled");
  drive_idle_a: assert property (all_off |-> drive_strength_o == 2'b00)
    else $error("drive set with outputs off");
  drive_code_a: assert property (drive_strength_o != 2'b11)
    else $error("unallocated drive code");
  // =====================
  // registers, divider, read-out
  div_gap_a: assert property (!div_tick_o |=> div_tick_o)
    else $error("two idle divider cycles");
  rd_new_a: assert property ((reg_wr_i && reg_addr_i == 8'h16)
    ##1 (reg_rd_i && !reg_wr_i && reg_addr_i == 8'h16)
    |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("stale readback");
  rd_unmap_a: assert property (reg_rd_i && reg_addr_i > 8'h17
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  col_hold_a: assert property ((!pix_adv_i && !field_start_i
    && !reg_wr_i)[*3] |=> $stable(col_addr_o)) else $error("column moved");
  cover property (sav_i);
  cover property (field_start_i ##1 data_oe_b_o);
  cover property (!div_tick_o);
endmodule
bind sensor_output_pin_control pin_ctrl_sva chk(.clk_i, .rst_b_i,
  .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .out_disable_pin_i,
  .field_start_i, .pix_adv_i, .sav_i, .reg_rdata_o, .data_oe_b_o,
  .frame_strobe_oe_b_o, .line_strobe_oe_b_o, .qualifier_clock_oe_b_o,
  .drive_strength_o, .div_tick_o, .col_addr_o);

/* sim/tb_top.sv */
// Purpose: random and corner tests of the pin control block
// Assumes: inputs change on falling edge
// Notes: small array of 6 rows by 8 columns
`timescale 1ns/1ps
module tb_top;
  localparam int R = 6;
  localparam int C = 8;
  logic clk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic out_disable_pin_i = 0, field_start_i = 0, pix_adv_i = 0;
  logic sav_i = 0, eav_i = 0, frame_strobe_i = 0, line_strobe_i = 0;
  logic qual_clk_i = 0, qual_clk_free_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, adc_data_i = 0;
  logic [7:0] reg_rdata_o, data_o, bus, v, e;
  logic data_oe_b_o, frame_strobe_pin_o, frame_strobe_oe_b_o;
  logic line_strobe_pin_o, line_strobe_oe_b_o, qualifier_clock_pin_o;
  logic qualifier_clock_oe_b_o, div_tick_o;
  logic [1:0] drive_strength_o;
  logic [8:0] row_addr_o, col_addr_o;
  integer seed = 22921, mismatches = 0, tests_run = 0, cycles = 0;
  integer i, k, n;
  sensor_output_pin_control #(.ROWS(R), .COLS(C)) dut(.clk_i, .rst_b_i,
    .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .out_disable_pin_i,
    .field_start_i, .pix_adv_i, .sav_i, .eav_i, .adc_data_i,
    .frame_strobe_i, .line_strobe_i, .qual_clk_i, .qual_clk_free_i,
    .reg_rdata_o,
    .data_o, .data_oe_b_o, .frame_strobe_pin_o, .frame_strobe_oe_b_o,
    .line_strobe_pin_o, .line_strobe_oe_b_o, .qualifier_clock_pin_o,
    .qualifier_clock_oe_b_o, .drive_strength_o, .div_tick_o,
    .row_addr_o, .col_addr_o);
  video_sink sink(.clk_i, .data_i(data_o), .oe_b_i(data_oe_b_o),
    .bus_o(bus));
  // =====================
  // clock and hang guard
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles = cycles + 1;
    if (cycles == 6000)
    begin
      mismatches = mismatches + 1;
      end_of_test;
    end
  end
  // idle cycles; both bus strobes drop here, wr and rd drop only the other one
  task automatic cyc(input integer c);
    reg_wr_i = 0;
    reg_rd_i = 0;
    repeat (c) @(negedge clk_i);
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // strobe stays up across back-to-back transfers of one kind
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_rd_i = 0;
    reg_wr_i = 1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    reg_wr_i = 0;
    reg_rd_i = 1;
    reg_addr_i = a;
    @(negedge clk_i);
    chk(reg_rdata_o, x);
  endtask
  task automatic fs;
    field_start_i = 1;
    cyc(1);
    field_start_i = 0;
    cyc(2);
  endtask
  // row expected for counter row r: shuffle first, then flip
  function automatic logic [8:0] erow(input integer r, input logic [7:0] c);
    integer x;
    x = c[2] ? (r < (R + 1) / 2 ? 2 * r : 2 * (r - (R + 1) / 2) + 1) : r;
    return 9'(c[4] ? R - 1 - x : x);
  endfunction
  task automatic end_of_test;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // =====================
  // main sequence
  initial
  begin
    cyc(20);
    rst_b_i = 1;
    cyc(1);
    rd(8'h15, 8'h00);
    rd(8'h16, 8'h03);
    rd(8'h17, 8'h18);
    rd(8'h20, 8'h00);
    for (i = 0; i < 8; i++)
    begin
      v = $random(seed);
      wr(8'h16, v);
      rd(8'h16, v);
    end
    $display("test registers done");
    wr(8'h17, 8'h20);
    wr(8'h16, 8'h00);
    cyc(2);
    chk(data_oe_b_o, 1);
    wr(8'h17, 8'h40);
    wr(8'h16, 8'h60);
    cyc(3);
    chk(data_oe_b_o, 1);
    chk(frame_strobe_oe_b_o, 0);
    fs;
    chk(data_oe_b_o, 0);
    chk(line_strobe_oe_b_o, 1);
    wr(8'h16, 8'h20);
    wr(8'h17, 8'h00);
    cyc(2);
    chk(qualifier_clock_oe_b_o, 0);
    chk(frame_strobe_oe_b_o, 1);
    for (i = 0; i < 3; i++)
    begin
      wr(8'h15, 8'(i << 3));
      cyc(2);
      chk(drive_strength_o, i);
    end
    out_disable_pin_i = 1;
    cyc(2);
    chk({data_oe_b_o, qualifier_clock_oe_b_o}, 2'b11);
    chk(drive_strength_o, 0);
    out_disable_pin_i = 0;
    $display("test tristate done");
    wr(8'h16, 8'h00);
    wr(8'h15, 8'h05);
    cyc(2);
    chk({frame_strobe_pin_o, qualifier_clock_pin_o}, 2'b10);
    wr(8'h15, 8'h03);
    cyc(2);
    chk({frame_strobe_pin_o, qualifier_clock_pin_o}, 2'b01);
    wr(8'h15, 8'h00);
    frame_strobe_i = 1;
    qual_clk_i = 1;
    cyc(2);
    chk(frame_strobe_pin_o, 1);
    wr(8'h17, 8'h04);
    cyc(2);
    chk({frame_strobe_pin_o, qualifier_clock_pin_o}, 2'b00);
    qual_clk_free_i = 1;
    cyc(2);
    chk(qualifier_clock_pin_o, 1);
    $display("test override done");
    wr(8'h17, 8'h02);
    adc_data_i = 8'h5a;
    for (k = 0; k < 2; k++)
    begin
      cyc(3);
      sav_i = (k == 0);
      eav_i = (k == 1);
      cyc(1);
      sav_i = 0;
      eav_i = 0;
      n = 0;
      while (data_o !== 8'hff && n < 6)
      begin
        cyc(1);
        n++;
      end
      chk(data_o, 8'hff);
      chk(line_strobe_pin_o, 1);
      for (i = 0; i < 3; i++)
      begin
        cyc(1);
        e = i < 2 ? 8'h00 : (k ? 8'h90 : 8'h80);
        chk(data_o, e);
        chk(frame_strobe_pin_o, e[5]);
      end
    end
    wr(8'h17, 8'h06);
    for (i = 0; i < 6; i++)
    begin
      adc_data_i = $random(seed);
      cyc(2);
      chk(bus, adc_data_i);
    end
    // narrow buses: 5-wire marks the high nibble, 4-wire does not
    adc_data_i = 8'ha5;
    for (k = 0; k < 2; k++)
    begin
      wr(8'h17, k ? 8'h05 : 8'h04);
      e = k ? 8'h0a : 8'h1a;
      n = 0;
      cyc(2);
      while (data_o !== e && n < 4)
      begin
        cyc(1);
        n++;
      end
      chk(data_o, e);
      cyc(1);
      chk(data_o, 8'h05);
    end
    $display("test video done");
    for (i = 0; i < 6; i++)
    begin
      v = $random(seed) & 8'h1c;
      wr(8'h16, v);
      fs;
      n = 1 + {$random(seed)} % 40;
      pix_adv_i = 1;
      cyc(n);
      pix_adv_i = 0;
      cyc(3);
      chk(row_addr_o, erow(n / C, v));
      chk(col_addr_o, 9'(v[3] ? C - 1 - n % C : n % C));
    end
    wr(8'h16, 8'h80);
    cyc(3);
    n = 0;
    repeat (30)
    begin
      cyc(1);
      n += !div_tick_o;
    end
    chk(n, 10);
    $display("test readout done");
    end_of_test;
  end
endmodule

/* sim/video_sink.sv */
// Purpose: coprocessor side of the data bus
// Assumes: samples on clk_i rise
// Notes: released bus shows inverse of last byte
`timescale 1ns/1ps
module video_sink(
  input wire logic clk_i,
  input wire logic [7:0] data_i,
  input wire logic oe_b_i,
  output logic [7:0] bus_o
);
  logic [7:0] last_ff;
  // keep last driven byte; floating bus must not look valid
  always_ff @(posedge clk_i)
    if (!oe_b_i)
      last_ff <= data_i;
  assign bus_o = oe_b_i ? ~last_ff : data_i;
endmodule
